// ===== logic/addr_gen_pkg.sv
package addr_gen_pkg;
    localparam int ADDR_W    = 12;
    localparam int BYTE_W    = 8;
    localparam int JUMP_W    = 20;
    localparam int NUM_PAIRS = 3;
    localparam int HI_USED_W = 4;
    localparam int JUMP_HI_W = 12;
    // Opcode field positions
    localparam int OP_A_BIT  = 8;
    localparam int OP_D_BIT  = 9;
    // Access bank split and the bank its upper part maps to
    localparam logic [7:0] ACCESS_SPLIT   = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    // Virtual operand block of each pair, counted down from its plain operand
    localparam logic [11:0] IND_OPERAND_ONE_ADDR = 12'hFE7;
    localparam logic [11:0] VOP_BASE_0 = 12'hFEF;
    localparam logic [11:0] VOP_BASE_2 = 12'hFDF;
    localparam logic [11:0] VOP_SPAN   = 12'h007;
    localparam logic [11:0] PTR_RESET  = 12'h000;
    localparam logic [11:0] STEP_ONE   = 12'h001;

    typedef enum logic [1:0] {
        KIND_FILE = 2'h0,
        KIND_LONG = 2'h1,
        KIND_JUMP = 2'h3
    } req_kind_t;

    // Down-counted slot within a pair's block, plus one
    typedef enum logic [2:0] {
        VK_NONE, VK_INDF, VK_POST_INCREMENT_OPERAND, VK_POST_DECREMENT_OPERAND, VK_PRE_INCREMENT_OPERAND, VK_W_OFFSET_OPERAND, VK_HI, VK_LO
    } vk_t;

    typedef struct packed {
        vk_t        kind;
        logic [1:0] pair;
    } vdec_t;
endpackage

// ===== logic/ptr_ctl_if.sv
`timescale 1ns/100ps
// Control and value of one pointer pair
interface ptr_ctl_if;
    logic        ld_lo;
    logic        ld_hi;
    logic        inc;
    logic        dec;
    logic [7:0]  wbyte;
    logic [11:0] value;
    modport owner (input ld_lo, input ld_hi, input inc, input dec, input wbyte, output value);
    modport user  (output ld_lo, output ld_hi, output inc, output dec, output wbyte, input value);
endinterface

// ===== logic/ptr_pair.sv
`timescale 1ns/100ps
module ptr_pair (
    input  wire logic core_clk_i,
    input  wire logic rst_b_i,
    ptr_ctl_if.owner  ctl
);
    import addr_gen_pkg::*;

    typedef struct packed {
        logic [ADDR_W-1:0] val;
    } pp_st_t;

    pp_st_t st;
    pp_st_t next_st;

    // A byte load wins over a step, so a value stored through the pair's own
    // operand is kept exactly as written
    always_comb begin
        next_st = st;
        if (ctl.ld_lo) begin
            next_st.val[7:0] = ctl.wbyte;
        end else if (ctl.ld_hi) begin
            next_st.val[ADDR_W-1:BYTE_W] = ctl.wbyte[HI_USED_W-1:0];
        end else if (ctl.inc) begin
            next_st.val = st.val + STEP_ONE;
        end else if (ctl.dec) begin
            next_st.val = st.val - STEP_ONE;
        end
    end

    // Twelve bits held, so the unused high nibble has no storage
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st.val <= PTR_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign ctl.value = st.val;
endmodule

// ===== logic/data_addr_gen.sv
`timescale 1ns/100ps
module data_addr_gen (
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_b_i,
    input  wire logic                           req_valid_i,
    input  wire addr_gen_pkg::req_kind_t        req_kind_i,
    input  wire logic                           req_write_i,
    input  wire logic [15:0]                    op_word_i,
    input  wire logic [15:0]                    op_hi_i,
    input  wire logic [addr_gen_pkg::ADDR_W-1:0] long_addr_i,
    input  wire logic                           d_present_i,
    input  wire logic                           implied_file_i,
    input  wire logic [7:0]                     wdata_i,
    input  wire logic [7:0]                     w_i,
    input  wire logic [3:0]                     bank_sel_i,
    input  wire logic [7:0]                     ram_rdata_i,
    output logic [addr_gen_pkg::ADDR_W-1:0]     ram_addr_o,
    output logic                                ram_re_o,
    output logic                                ram_we_o,
    output logic [7:0]                          ram_wdata_o,
    output logic                                rd_valid_o,
    output logic [7:0]                          rd_data_o,
    output logic                                dest_file_o,
    output logic [addr_gen_pkg::ADDR_W-1:0]     res_addr_o,
    output logic                                jump_valid_o,
    output logic [addr_gen_pkg::JUMP_W-1:0]     jump_target_o
);
    import addr_gen_pkg::*;

    typedef struct packed {
        logic [ADDR_W-1:0] ram_addr;
        logic              ram_re;
        logic              ram_we;
        logic [7:0]        ram_wdata;
        logic              s1_rd;
        logic              s1_int;
        logic [7:0]        s1_val;
        logic              s1_dest;
        logic [ADDR_W-1:0] s1_addr;
        logic              rd_valid;
        logic [7:0]        rd_data;
        logic              dest_file;
        logic [ADDR_W-1:0] res_addr;
        logic              jump_valid;
        logic [JUMP_W-1:0] jump_target;
    } st_t;

    st_t                    st;
    st_t                    next_st;
    logic [ADDR_W-1:0]      ptr_val [NUM_PAIRS];
    logic [NUM_PAIRS-1:0]   ld_lo;
    logic [NUM_PAIRS-1:0]   ld_hi;
    logic [NUM_PAIRS-1:0]   inc;
    logic [NUM_PAIRS-1:0]   dec;
    logic [ADDR_W-1:0]      dir;
    logic [ADDR_W-1:0]      tgt;
    logic [ADDR_W-1:0]      cur_ptr;
    vdec_t                  dv;
    vdec_t                  tv;
    logic                   indirect;
    logic                   tgt_virt;

    // Base of each pair's operand block, plain operand first
    function automatic logic [ADDR_W-1:0] vop_base(input int i);
        logic [ADDR_W-1:0] b;
        b = VOP_BASE_2;
        if (i == 0) begin
            b = VOP_BASE_0;
        end else if (i == 1) begin
            b = IND_OPERAND_ONE_ADDR;
        end
        return b;
    endfunction

    // Classify an address as a virtual operand or pointer byte of some pair
    function automatic vdec_t vdecode(input logic [ADDR_W-1:0] a);
        vdec_t             r;
        logic [ADDR_W-1:0] off;
        r.kind = VK_NONE;
        r.pair = 2'h0;
        for (int i = 0; i < NUM_PAIRS; i++) begin
            off = vop_base(i) - a;
            if (off < VOP_SPAN) begin
                r.kind = vk_t'(off[2:0] + 3'h1);
                r.pair = 2'(i);
            end
        end
        return r;
    endfunction

    // One pointer pair per instance
    for (genvar g = 0; g < NUM_PAIRS; g++) begin : g_pair
        ptr_ctl_if pif ();
        assign pif.ld_lo = ld_lo[g];
        assign pif.ld_hi = ld_hi[g];
        assign pif.inc   = inc[g];
        assign pif.dec   = dec[g];
        assign pif.wbyte = wdata_i;
        assign ptr_val[g] = pif.value;
        ptr_pair u_pair (
            .core_clk_i (core_clk_i),
            .rst_b_i    (rst_b_i),
            .ctl        (pif.owner)
        );
    end

    // Direct address: long moves bypass banking, else bank bit picks the map
    always_comb begin
        if (req_kind_i == KIND_LONG) begin
            dir = long_addr_i;
        end else if (op_word_i[OP_A_BIT]) begin
            dir = {bank_sel_i, op_word_i[7:0]};
        end else if (op_word_i[7:0] >= ACCESS_SPLIT) begin
            dir = {ACCESS_HI_BANK, op_word_i[7:0]};
        end else begin
            dir = {ACCESS_LO_BANK, op_word_i[7:0]};
        end
    end

    // Indirect target comes from the pointer, plus one for pre-increment and W for the offset operand, never from the bank
    always_comb begin
        dv       = vdecode(dir);
        cur_ptr  = ptr_val[dv.pair];
        indirect = dv.kind inside {VK_INDF, VK_POST_INCREMENT_OPERAND, VK_POST_DECREMENT_OPERAND, VK_PRE_INCREMENT_OPERAND, VK_W_OFFSET_OPERAND};
        case (dv.kind)
            VK_INDF:    tgt = cur_ptr;
            VK_POST_INCREMENT_OPERAND: tgt = cur_ptr;
            VK_POST_DECREMENT_OPERAND: tgt = cur_ptr;
            VK_PRE_INCREMENT_OPERAND:  tgt = cur_ptr + STEP_ONE;
            VK_W_OFFSET_OPERAND:   tgt = cur_ptr + {{HI_USED_W{w_i[7]}}, w_i};
            default:    tgt = dir;
        endcase
        tv       = vdecode(tgt);
        tgt_virt = indirect && tv.kind inside {VK_INDF, VK_POST_INCREMENT_OPERAND, VK_POST_DECREMENT_OPERAND,
                                               VK_PRE_INCREMENT_OPERAND, VK_W_OFFSET_OPERAND};
    end

    // Request handling and the read-return stage
    always_comb begin
        next_st            = st;
        next_st.ram_re     = 1'b0;
        next_st.ram_we     = 1'b0;
        next_st.s1_rd      = 1'b0;
        next_st.rd_valid   = 1'b0;
        next_st.jump_valid = 1'b0;
        ld_lo              = '0;
        ld_hi              = '0;
        inc                = '0;
        dec                = '0;
        // RAM read data is taken in the cycle the strobe stands
        if (st.s1_rd) begin
            next_st.rd_valid  = 1'b1;
            next_st.rd_data   = st.s1_int ? st.s1_val : ram_rdata_i;
            next_st.dest_file = st.s1_dest;
            next_st.res_addr  = st.s1_addr;
        end
        if (req_valid_i && req_kind_i == KIND_JUMP) begin
            next_st.jump_valid  = 1'b1;
            next_st.jump_target = {op_hi_i[JUMP_HI_W-1:0], op_word_i[7:0]};
        end else if (req_valid_i) begin
            next_st.s1_rd   = !req_write_i;
            next_st.s1_int  = 1'b1;
            next_st.s1_val  = 8'h00;
            next_st.s1_addr = tgt;
            // Without a d bit the instruction supplies its own destination
            next_st.s1_dest = d_present_i ? op_word_i[OP_D_BIT] : implied_file_i;
            // Only pointer moves happen here; status flags live elsewhere
            if (dv.kind inside {VK_POST_INCREMENT_OPERAND, VK_PRE_INCREMENT_OPERAND}) begin
                inc[dv.pair] = 1'b1;
            end else if (dv.kind == VK_POST_DECREMENT_OPERAND) begin
                dec[dv.pair] = 1'b1;
            end
            if (tgt_virt) begin
                // Reads return the zero preset, writes are dropped
                next_st.s1_val = 8'h00;
            end else if (tv.kind == VK_LO || tv.kind == VK_HI) begin
                // Pointer bytes are plain registers to every access
                if (req_write_i) begin
                    ld_lo[tv.pair] = tv.kind == VK_LO;
                    ld_hi[tv.pair] = tv.kind == VK_HI;
                    if (indirect && tv.pair == dv.pair) begin
                        inc[dv.pair] = 1'b0;
                        dec[dv.pair] = 1'b0;
                    end
                end else if (tv.kind == VK_LO) begin
                    next_st.s1_val = ptr_val[tv.pair][7:0];
                end else begin
                    next_st.s1_val = {4'h0, ptr_val[tv.pair][ADDR_W-1:BYTE_W]};
                end
            end else begin
                // Everything else, other special registers included, goes to RAM
                next_st.s1_int    = 1'b0;
                next_st.ram_addr  = tgt;
                next_st.ram_re    = !req_write_i;
                next_st.ram_we    = req_write_i;
                next_st.ram_wdata = wdata_i;
            end
        end
    end

    // Synchronous reset clears the outputs and the return stage together
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ram_addr_o    = st.ram_addr;
    assign ram_re_o      = st.ram_re;
    assign ram_we_o      = st.ram_we;
    assign ram_wdata_o   = st.ram_wdata;
    assign rd_valid_o    = st.rd_valid;
    assign rd_data_o     = st.rd_data;
    assign dest_file_o   = st.dest_file;
    assign res_addr_o    = st.res_addr;
    assign jump_valid_o  = st.jump_valid;
    assign jump_target_o = st.jump_target;

    // Checks on the generated addresses and pointer behaviour
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    logic file_req;
    logic plain_req;
    logic data_req;
    assign file_req  = req_valid_i && req_kind_i == KIND_FILE;
    assign plain_req = req_valid_i && req_kind_i != KIND_JUMP && dv.kind == VK_NONE;
    // Jumps carry no operand, so pointer checks look at data requests only
    assign data_req  = req_valid_i && req_kind_i != KIND_JUMP;

    chk_jump_target: assert property (
        req_valid_i && req_kind_i == KIND_JUMP |=> jump_valid_o
            && jump_target_o == {$past(op_hi_i[11:0]), $past(op_word_i[7:0])})
        else $error("jump target not taken from opcode");
    chk_bank_addr: assert property (
        file_req && plain_req && op_word_i[OP_A_BIT] && !req_write_i
            |=> ram_re_o && ram_addr_o == {$past(bank_sel_i), $past(op_word_i[7:0])})
        else $error("banked address wrong");
    chk_access_map: assert property (
        file_req && plain_req && !op_word_i[OP_A_BIT] && !req_write_i
            |=> ram_addr_o[11:8] == ($past(op_word_i[7:0]) >= ACCESS_SPLIT ? 4'hF : 4'h0))
        else $error("access bank mapping wrong");
    chk_long_addr: assert property (
        plain_req && req_kind_i == KIND_LONG && req_write_i
            |=> ram_we_o && ram_addr_o == $past(long_addr_i))
        else $error("long address not used whole");
    chk_dest_sel: assert property (
        file_req && !req_write_i && d_present_i |-> ##2 rd_valid_o
            && dest_file_o == $past(op_word_i[OP_D_BIT], 2))
        else $error("destination select wrong");

    // Virtual targets: reads give zero and never strobe the RAM
    chk_virt_read: assert property (
        data_req && tgt_virt && !req_write_i |=> !ram_re_o ##1 rd_valid_o
            && rd_data_o == 8'h00)
        else $error("virtual read not zero");
    chk_virt_write: assert property (
        req_valid_i && tgt_virt && req_write_i |=> !ram_we_o)
        else $error("virtual write reached memory");

    // Auto steps, unless a load into the same pair wins
    chk_post_inc: assert property (
        data_req && dv.kind == VK_POST_INCREMENT_OPERAND && !(ld_lo[dv.pair] || ld_hi[dv.pair])
            |=> ptr_val[$past(dv.pair)] == $past(cur_ptr) + STEP_ONE)
        else $error("post-increment step wrong");
    chk_post_dec: assert property (
        data_req && dv.kind == VK_POST_DECREMENT_OPERAND && !(ld_lo[dv.pair] || ld_hi[dv.pair])
            |=> ptr_val[$past(dv.pair)] == $past(cur_ptr) - STEP_ONE)
        else $error("post-decrement step wrong");

    // Offset operand moves neither the pointer nor the working register
    chk_offset_hold: assert property (
        data_req && dv.kind == VK_W_OFFSET_OPERAND && !tgt_virt && !(tv.kind inside {VK_LO, VK_HI})
            |=> ram_addr_o == $past(cur_ptr + {{4{w_i[7]}}, w_i})
            && ptr_val[$past(dv.pair)] == $past(cur_ptr))
        else $error("offset operand address or hold wrong");

    // Plain operand keeps its pointer
    chk_plain_hold: assert property (
        data_req && dv.kind == VK_INDF && !(ld_lo[dv.pair] || ld_hi[dv.pair])
            |=> ptr_val[$past(dv.pair)] == $past(cur_ptr))
        else $error("plain operand moved its pointer");

    // Indirect address is the bare pointer, whatever the bank says
    chk_ind_target: assert property (
        data_req && dv.kind == VK_INDF && !tgt_virt && !(tv.kind inside {VK_LO, VK_HI})
            |=> (ram_re_o || ram_we_o) && ram_addr_o == $past(cur_ptr))
        else $error("indirect address not the pointer");

    // Pre-increment uses the stepped value and keeps it
    chk_pre_inc: assert property (
        data_req && dv.kind == VK_PRE_INCREMENT_OPERAND && !tgt_virt && !(tv.kind inside {VK_LO, VK_HI})
            |=> ram_addr_o == $past(cur_ptr) + STEP_ONE
            && ptr_val[$past(dv.pair)] == $past(cur_ptr) + STEP_ONE)
        else $error("pre-increment address or step wrong");

    // Low byte rollover carries into the high byte
    chk_step_carry: assert property (
        data_req && dv.kind == VK_POST_INCREMENT_OPERAND && cur_ptr[7:0] == 8'hFF
            && !(ld_lo[dv.pair] || ld_hi[dv.pair])
            |=> ptr_val[$past(dv.pair)][11:8] == $past(cur_ptr[11:8]) + 4'h1)
        else $error("pointer step lost its carry");

    // Store through an own operand keeps the written byte unstepped
    chk_self_store: assert property (
        data_req && indirect && req_write_i && tv.kind == VK_LO && tv.pair == dv.pair
            |=> ptr_val[$past(dv.pair)] == {$past(cur_ptr[11:8]), $past(wdata_i)})
        else $error("own pair store was stepped");

    // Direct writes load the pointer bytes like any register
    chk_direct_load: assert property (
        data_req && !indirect && req_write_i && dv.kind == VK_LO
            |=> ptr_val[$past(dv.pair)][7:0] == $past(wdata_i))
        else $error("pointer low byte not loaded");

    // High byte keeps only four bits of a write
    chk_high_write: assert property (
        data_req && !indirect && req_write_i && dv.kind == VK_HI
            |=> ptr_val[$past(dv.pair)] == {$past(wdata_i[3:0]), $past(cur_ptr[7:0])})
        else $error("pointer high byte write wrong");

    // High byte reads back with a zero upper nibble
    chk_high_read: assert property (
        data_req && !req_write_i && tv.kind == VK_HI
            |-> ##2 rd_valid_o && rd_data_o == {4'h0, $past(ptr_val[tv.pair][11:8], 2)})
        else $error("pointer high byte read wrong");

    // Indirect writes to ordinary registers reach the RAM
    chk_other_write: assert property (
        data_req && indirect && req_write_i && !tgt_virt && !(tv.kind inside {VK_LO, VK_HI})
            |=> ram_we_o && ram_addr_o == $past(tgt) && ram_wdata_o == $past(wdata_i))
        else $error("indirect write lost");

    // File operand low address is the opcode byte
    chk_file_low: assert property (
        plain_req && req_kind_i == KIND_FILE
            |=> (ram_re_o || ram_we_o) && ram_addr_o[7:0] == $past(op_word_i[7:0]))
        else $error("file address byte wrong");

    cov_post_inc: cover property (req_valid_i && dv.kind == VK_POST_INCREMENT_OPERAND ##1 ram_we_o);
    cov_virt_read: cover property (req_valid_i && tgt_virt && !req_write_i);
    cov_jump: cover property (jump_valid_o);
    cov_pre_inc: cover property (data_req && dv.kind == VK_PRE_INCREMENT_OPERAND ##1 ram_we_o);
    cov_self_write: cover property (req_valid_i && indirect && req_write_i
        && tv.kind == VK_LO && tv.pair == dv.pair);
endmodule

// ===== dv/data_ram_model.sv
`timescale 1ns/100ps
// Behavioural data RAM on the far side of the address generator
module data_ram_model (
    input  wire logic        core_clk_i,
    input  wire logic [11:0] ram_addr_i,
    input  wire logic        ram_re_i,
    input  wire logic        ram_we_i,
    input  wire logic [7:0]  ram_wdata_i,
    output logic [7:0]       ram_rdata_o
);
    logic [7:0] mem [4096];
    logic [7:0] last = 8'h00;

    // Address-dependent fill, so a wrong address shows up as wrong data
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'(i) ^ 8'(i >> 4) ^ 8'hA5;
        end
    end

    // Write on the edge that sees the strobe and keep the last byte read
    always @(posedge core_clk_i) begin
        if (ram_we_i) begin
            mem[ram_addr_i] <= ram_wdata_i;
        end
        if (ram_re_i) begin
            last <= mem[ram_addr_i];
        end
    end

    // Outside a read the bus shows the inverse, so a late sample cannot pass by luck
    assign ram_rdata_o = ram_re_i ? mem[ram_addr_i] : ~last;
endmodule

// ===== dv/tb.sv
`timescale 1ns/100ps
module tb;
    import addr_gen_pkg::*;
    logic        core_clk_i  = 1'b0;
    logic        rst_b_i     = 1'b0;
    logic        req_valid_i = 1'b0;
    req_kind_t   req_kind_i  = KIND_FILE;
    logic        req_write_i = 1'b0;
    logic        d_present_i = 1'b0;
    logic        implied_file_i = 1'b0;
    logic [15:0] op_word_i   = 16'h0000;
    logic [15:0] op_hi_i     = 16'h0000;
    logic [11:0] long_addr_i = 12'h000;
    logic [7:0]  wdata_i     = 8'h00;
    logic [7:0]  w_i         = 8'h00;
    logic [3:0]  bank_sel_i  = 4'h0;
    logic [7:0]  ram_rdata_i, ram_wdata_o, rd_data_o;
    logic [11:0] ram_addr_o, res_addr_o;
    logic        ram_re_o, ram_we_o, rd_valid_o, dest_file_o, jump_valid_o;
    logic [19:0] jump_target_o;
    int          fail_count  = 0;
    int          checks_done = 0;
    logic [11:0] ptr [3]     = '{default: 12'h000};
    logic [11:0] bs [3]      = '{VOP_BASE_0, IND_OPERAND_ONE_ADDR, VOP_BASE_2};
    logic [7:0]  shadow [4096];
    logic [20:0] q_ram [$];
    logic [20:0] q_rd [$];
    logic [19:0] q_jmp [$];

    // Free-running core clock, 5 ns period
    always #2.5 core_clk_i = ~core_clk_i;

    data_addr_gen dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
        .req_kind_i(req_kind_i), .req_write_i(req_write_i), .op_word_i(op_word_i),
        .op_hi_i(op_hi_i), .long_addr_i(long_addr_i), .d_present_i(d_present_i),
        .implied_file_i(implied_file_i), .wdata_i(wdata_i), .w_i(w_i), .bank_sel_i(bank_sel_i),
        .ram_rdata_i(ram_rdata_i), .ram_addr_o(ram_addr_o), .ram_re_o(ram_re_o),
        .ram_we_o(ram_we_o), .ram_wdata_o(ram_wdata_o), .rd_valid_o(rd_valid_o),
        .rd_data_o(rd_data_o), .dest_file_o(dest_file_o), .res_addr_o(res_addr_o),
        .jump_valid_o(jump_valid_o), .jump_target_o(jump_target_o));

    data_ram_model ram (.core_clk_i(core_clk_i), .ram_addr_i(ram_addr_o), .ram_re_i(ram_re_o),
        .ram_we_i(ram_we_o), .ram_wdata_i(ram_wdata_o), .ram_rdata_o(ram_rdata_i));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // Slot of an address inside a pair's operand block, -1 when outside all blocks
    function automatic int slot(input logic [11:0] x, output int n);
        slot = -1;
        n = 0;
        for (int i = 0; i < 3; i++) begin
            if (x <= bs[i] && bs[i] - x <= 12'h006) begin
                slot = int'(bs[i] - x);
                n = i;
            end
        end
    endfunction

    // One request; the reference pointer and RAM copies decide every expected result except the jump target
    task automatic send(input req_kind_t kd, input logic wr, input logic [11:0] la,
                        input logic [9:0] ob, input logic [7:0] wd, input logic [7:0] wv);
        logic [11:0] a, x, np;
        logic [11:0] old [3];
        logic [7:0]  rv;
        logic        dst, ind;
        int          k, n, tk, tn;
        @(negedge core_clk_i);
        req_valid_i = 1'b1;
        req_kind_i = kd;
        req_write_i = wr;
        op_word_i = {6'($urandom), ob};
        op_hi_i = 16'($urandom);
        long_addr_i = la;
        d_present_i = 1'($urandom);
        implied_file_i = 1'($urandom);
        wdata_i = wd;
        w_i = wv;
        bank_sel_i = 4'($urandom);
        if (kd == KIND_JUMP) begin
            q_jmp.push_back({op_hi_i[11:0], ob[7:0]});
            return;
        end
        dst = d_present_i ? ob[9] : implied_file_i;
        a = (kd == KIND_LONG) ? la : ob[8] ? {bank_sel_i, ob[7:0]}
            : {(ob[7:0] >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK, ob[7:0]};
        k = slot(a, n);
        ind = (k >= 0) && (k <= 4);
        x = ind ? ptr[n] + 12'(k == 3) + ((k == 4) ? {{4{wv[7]}}, wv} : 12'h000) : a;
        np = ptr[n] + ((k == 1 || k == 3) ? STEP_ONE : (k == 2) ? 12'hFFF : 12'h000);
        old = ptr;
        if (ind) ptr[n] = np;
        tk = slot(x, tn);
        if (ind && tk >= 0 && tk <= 4) rv = 8'h00;
        else if (tk >= 5) begin
            rv = (tk == 5) ? {4'h0, old[tn][11:8]} : old[tn][7:0];
            if (wr && ind && tn == n) ptr[n] = old[n];
            if (wr && tk == 5) ptr[tn][11:8] = wd[3:0];
            if (wr && tk == 6) ptr[tn][7:0] = wd;
        end else begin
            rv = shadow[x];
            q_ram.push_back({wr, x, wr ? wd : 8'h00});
            if (wr) shadow[x] = wd;
        end
        if (!wr) q_rd.push_back({rv, x, dst});
    endtask

    task automatic lg(input logic [11:0] a, input logic wr, input logic [7:0] wd,
                      input logic [7:0] wv);
        send(KIND_LONG, wr, a, 10'($urandom), wd, wv);
    endtask

    task automatic idle;
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
    endtask

    // Results are matched in arrival order against the oldest note of their kind
    always @(negedge core_clk_i) begin
        if (rst_b_i) begin
            if (ram_re_o || ram_we_o) begin
                if (q_ram.size() == 0) check(1, 0, "stray ram strobe");
                else check({ram_we_o, ram_addr_o, ram_we_o ? ram_wdata_o : 8'h00},
                           q_ram.pop_front(), "ram access");
            end
            if (rd_valid_o) begin
                if (q_rd.size() == 0) check(1, 0, "stray read result");
                else check({rd_data_o, res_addr_o, dest_file_o}, q_rd.pop_front(), "read");
            end
            if (jump_valid_o) begin
                if (q_jmp.size() == 0) check(1, 0, "stray jump");
                else check(jump_target_o, q_jmp.pop_front(), "jump target");
            end
        end
    end

    // Main sequence
    initial begin
        int r;
        void'($urandom(37));
        for (int i = 0; i < 4096; i++) shadow[i] = 8'(i) ^ 8'(i >> 4) ^ 8'hA5;
        repeat (5) @(negedge core_clk_i);
        check({ram_re_o, ram_we_o, rd_valid_o, jump_valid_o, ram_addr_o}, 0, "reset outputs");
        rst_b_i = 1'b1;
        // Load each pair with 0nFFh through its bytes, junk in the unused nibble
        for (int n = 0; n < 3; n++) begin
            lg(bs[n] - 12'h006, 1'b1, 8'hFF, 8'h00);
            lg(bs[n] - 12'h005, 1'b1, 8'hF0 | 8'(n), 8'h00);
            lg(bs[n] - 12'h005, 1'b0, 8'h00, 8'h00);
        end
        // Every operand of every pair back to back, pointer read after each
        for (int n = 0; n < 3; n++) begin
            for (int k = 0; k < 5; k++) begin
                lg(bs[n] - 12'(k), 1'(k & 1), 8'(k + 8'h30), n[0] ? 8'h80 : 8'h7F);
                lg(bs[n] - 12'h006, 1'b0, 8'h00, 8'h00);
                lg(bs[n] - 12'h005, 1'b0, 8'h00, 8'h00);
            end
        end
        // Pair zero aimed at a virtual operand: read gives zero, write is dropped
        lg(12'hFE9, 1'b1, 8'hE7, 8'h00);
        lg(12'hFEA, 1'b1, 8'h0F, 8'h00);
        lg(12'hFEF, 1'b0, 8'h00, 8'h00);
        lg(12'hFEF, 1'b1, 8'h55, 8'h00);
        lg(12'hFEE, 1'b0, 8'h00, 8'h00);
        // Pair two aimed at its own low byte, pair one at pair two's low byte
        lg(12'hFD9, 1'b1, 8'hD9, 8'h00);
        lg(12'hFDA, 1'b1, 8'h0F, 8'h00);
        lg(12'hFDD, 1'b1, 8'h34, 8'h00);
        lg(12'hFE1, 1'b1, 8'hD9, 8'h00);
        lg(12'hFE2, 1'b1, 8'h0F, 8'h00);
        lg(12'hFE6, 1'b1, 8'h77, 8'h00);
        lg(12'hFD9, 1'b0, 8'h00, 8'h00);
        lg(12'hFE1, 1'b0, 8'h00, 8'h00);
        // Random mix of file, long and jump requests with occasional gaps
        for (int i = 0; i < 80; i++) begin
            r = $urandom % 3;
            send(r == 0 ? KIND_FILE : r == 1 ? KIND_LONG : KIND_JUMP, 1'($urandom),
                 12'($urandom), 10'($urandom), 8'($urandom), 8'($urandom));
            if (r == 1) idle();
        end
        idle();
        repeat (4) @(negedge core_clk_i);
        // Mid-run reset: every pointer must read back zero afterwards
        rst_b_i = 1'b0;
        repeat (2) @(negedge core_clk_i);
        rst_b_i = 1'b1;
        ptr = '{default: 12'h000};
        for (int n = 0; n < 3; n++) begin
            lg(bs[n] - 12'h006, 1'b0, 8'h00, 8'h00);
            lg(bs[n] - 12'h005, 1'b0, 8'h00, 8'h00);
        end
        idle();
        repeat (4) @(negedge core_clk_i);
        check(q_ram.size() + q_rd.size() + q_jmp.size(), 0, "results missing");
        stop_test();
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        #10000;
        fail_count++;
        $display("BAD t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule
